//--- hdl/rtdob_consts.svh
// Object indices, subindices, entry counts, limits and key of the channel object bank
`ifndef RTDOB_CONSTS_SVH
`define RTDOB_CONSTS_SVH

`define RTDOB_IDX_RESTORE   16'h1011
`define RTDOB_IDX_INPUT     16'h6000
`define RTDOB_IDX_INTERNAL  16'h800e
`define RTDOB_IDX_VENDOR    16'h800f
`define RTDOB_IDX_PROFILE   16'hf000
`define RTDOB_IDX_CODE      16'hf008
`define RTDOB_IDX_MODLIST   16'hf010
`define RTDOB_CHAN_MASK     16'hff0f

`define RTDOB_SUB_COUNT     8'h00
`define RTDOB_SUB_BELOW     8'h01
`define RTDOB_SUB_ABOVE     8'h02
`define RTDOB_SUB_ERROR     8'h07
`define RTDOB_SUB_VALIDITY  8'h0f
`define RTDOB_SUB_TOGGLE    8'h10
`define RTDOB_SUB_READING   8'h11
`define RTDOB_SUB_RAW       8'h01
`define RTDOB_SUB_RES       8'h02
`define RTDOB_SUB_OFS_A     8'h01
`define RTDOB_SUB_GAIN_A    8'h02
`define RTDOB_SUB_OFS_B     8'h03
`define RTDOB_SUB_GAIN_B    8'h04
`define RTDOB_SUB_SPACING   8'h01
`define RTDOB_SUB_CHANNELS  8'h02

`define RTDOB_RESTORE_COUNT 8'h01
`define RTDOB_INPUT_COUNT   8'h11
`define RTDOB_INTERNAL_CNT  8'h04
`define RTDOB_VENDOR_COUNT  8'h04
`define RTDOB_PROFILE_COUNT 8'h02
`define RTDOB_SPACING       16'h0010
`define RTDOB_MAX_CHANNELS  8
`define RTDOB_PROFILE_NUM   32'h00000140
`define RTDOB_RESTORE_KEY   32'h64616f6c

`endif

//--- hdl/rtdob_pkg.sv
// Types shared by the channel object bank
package rtdob_pkg;

	typedef struct packed {
		logic        below;
		logic        above;
		logic        open_circuit;
		logic        invalid;
		logic [15:0] reading;
		logic [31:0] raw;
		logic [15:0] resistance;
	} rtdob_sample_s;

	typedef struct packed {
		logic        below;
		logic        above;
		logic        error;
		logic        validity;
		logic        toggle;
		logic [15:0] reading;
		logic [31:0] raw;
		logic [15:0] resistance;
	} rtdob_status_s;

	typedef struct packed {
		logic [15:0] offset_a;
		logic [15:0] gain_a;
		logic [15:0] offset_b;
		logic [15:0] gain_b;
	} rtdob_calib_s;

endpackage : rtdob_pkg

//--- hdl/rtdob_channel.sv
// One channel's input objects, captured together on each converter update
module rtdob_channel
(
	input  wire logic                   ref_clk,
	input  wire logic                   sys_rst,
	input  wire logic                   sample_valid,
	input  wire rtdob_pkg::rtdob_sample_s sample,
	output rtdob_pkg::rtdob_status_s    status
);

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	// Every field is loaded in the same edge
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			status <= '0;
		end
		else if (sample_valid)
		begin
			status.below      <= sample.below;
			status.above      <= sample.above | sample.open_circuit;
			status.error      <= sample.invalid | sample.open_circuit;
			status.validity   <= sample.invalid | sample.open_circuit;
			status.toggle     <= ~status.toggle;
			status.reading    <= sample.reading;
			status.raw        <= sample.raw;
			status.resistance <= sample.resistance;
		end
	end

	AST_BELOW_FOLLOWS: assert property (
		sample_valid |=> status.below == $past(sample.below))
		else $error("below flag does not follow sample");

	AST_ABOVE_FOLLOWS: assert property (
		sample_valid && !sample.open_circuit
		|=> status.above == $past(sample.above))
		else $error("above flag does not follow sample");

	AST_OPEN_BOTH: assert property (
		sample_valid && sample.open_circuit |=> status.above && status.error)
		else $error("open circuit not shown as above and error");

	AST_ERROR_VALID: assert property (
		sample_valid && !sample.invalid && !sample.open_circuit
		|=> !status.error)
		else $error("error flag set on valid data");

	AST_VALIDITY_ERR: assert property (
		sample_valid |=> status.validity
		== $past(sample.invalid || sample.open_circuit))
		else $error("validity bit does not show data validity");

	AST_TOGGLE_FLIP: assert property (
		sample_valid |=> status.toggle != $past(status.toggle))
		else $error("toggle did not invert on update");

	AST_TOGGLE_HOLD: assert property (
		!sample_valid |=> $stable(status))
		else $error("channel objects changed without update");

	AST_READING_RESET: assert property (@(posedge ref_clk)
		disable iff (1'b0)
		sys_rst |=> status.reading == 16'h0000 && !status.toggle)
		else $error("reading not zero after reset");

	AST_TOGETHER: assert property (
		sample_valid |=> status.reading == $past(sample.reading)
		&& status.raw == $past(sample.raw))
		else $error("channel fields not updated together");

endmodule : rtdob_channel

//--- hdl/rtdob_bank.sv
// Channel object bank of a multi-channel resistance thermometer input
`include "rtdob_consts.svh"

module rtdob_bank
#(
	parameter int          CHANNELS       = `RTDOB_MAX_CHANNELS,
	parameter logic [15:0] FACTORY_OFFSET = 16'h0000,
	parameter logic [15:0] FACTORY_GAIN   = 16'h4000
)
(
	input  wire logic                     ref_clk,
	input  wire logic                     sys_rst,
	input  wire logic [CHANNELS-1:0]      sample_valid,
	input  wire rtdob_pkg::rtdob_sample_s sample [CHANNELS],
	output rtdob_pkg::rtdob_calib_s       calib [CHANNELS],
	input  wire logic                     od_req,
	input  wire logic                     od_we,
	input  wire logic [15:0]              od_index,
	input  wire logic [7:0]               od_subindex,
	input  wire logic [31:0]              od_wdata,
	output logic                          od_ack,
	output logic                          od_err,
	output logic [31:0]                   od_rdata
);

	generate
		if (CHANNELS < 1 || CHANNELS > `RTDOB_MAX_CHANNELS)
		begin : g_bad_channels
			$error("CHANNELS must lie between 1 and 8");
		end
	endgenerate

	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	localparam logic [3:0] CH_LIMIT = 4'(CHANNELS);

	rtdob_pkg::rtdob_status_s status [CHANNELS];
	rtdob_pkg::rtdob_status_s sel_status;
	rtdob_pkg::rtdob_calib_s  sel_calib;
	logic [31:0]              restore_defaults_key;
	logic [31:0]              reserved_key_word;
	logic [2:0]               sel_ch;
	logic [31:0]              next_rdata;
	logic                     next_err;
	logic                     wr_ok;
	logic                     restore_hit;

	// True when the index falls in the block of a present channel
	function automatic logic chan_hit(input logic [15:0] idx,
		input logic [15:0] base);
		chan_hit = ((idx & `RTDOB_CHAN_MASK) == base)
			&& !idx[7] && ({1'b0, idx[6:4]} < CH_LIMIT);
	endfunction : chan_hit

	// Widens a one-bit flag to a data word
	function automatic logic [31:0] bit_word(input logic b);
		bit_word = {31'h0, b};
	endfunction : bit_word

	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++)
		begin : g_chan
			rtdob_channel u_channel
			(
				.ref_clk      (ref_clk),
				.sys_rst      (sys_rst),
				.sample_valid (sample_valid[gi]),
				.sample       (sample[gi]),
				.status       (status[gi])
			);
		end
	endgenerate

	assign sel_ch     = od_index[6:4];
	assign sel_status = status[sel_ch];
	assign sel_calib  = calib[sel_ch];

	// Read data, access errors and write acceptance
	always_comb
	begin
		next_rdata = 32'h00000000;
		next_err   = 1'b0;
		wr_ok      = 1'b0;
		if (od_index == `RTDOB_IDX_RESTORE)
		begin
			unique case (od_subindex)
				`RTDOB_SUB_COUNT:
				begin
					next_rdata = {24'h0, `RTDOB_RESTORE_COUNT};
					next_err   = od_we;
				end
				`RTDOB_SUB_RAW:
				begin
					next_rdata = restore_defaults_key;
					wr_ok      = od_we;
				end
				default:
					next_err = 1'b1;
			endcase
		end
		else if (chan_hit(od_index, `RTDOB_IDX_INPUT))
		begin
			unique case (od_subindex)
				`RTDOB_SUB_COUNT:
					next_rdata = {24'h0, `RTDOB_INPUT_COUNT};
				`RTDOB_SUB_BELOW:
					next_rdata = bit_word(sel_status.below);
				`RTDOB_SUB_ABOVE:
					next_rdata = bit_word(sel_status.above);
				`RTDOB_SUB_ERROR:
					next_rdata = bit_word(sel_status.error);
				`RTDOB_SUB_VALIDITY:
					next_rdata = bit_word(sel_status.validity);
				`RTDOB_SUB_TOGGLE:
					next_rdata = bit_word(sel_status.toggle);
				`RTDOB_SUB_READING:
					next_rdata = {{16{sel_status.reading[15]}},
						sel_status.reading};
				default:
					next_err = 1'b1;
			endcase
			if (od_we)
				next_err = 1'b1;
		end
		else if (chan_hit(od_index, `RTDOB_IDX_INTERNAL))
		begin
			unique case (od_subindex)
				`RTDOB_SUB_COUNT:
					next_rdata = {24'h0, `RTDOB_INTERNAL_CNT};
				`RTDOB_SUB_RAW:
					next_rdata = sel_status.raw;
				`RTDOB_SUB_RES:
					next_rdata = {16'h0, sel_status.resistance};
				default:
					next_err = 1'b1;
			endcase
			if (od_we)
				next_err = 1'b1;
		end
		else if (chan_hit(od_index, `RTDOB_IDX_VENDOR))
		begin
			wr_ok = od_we;
			unique case (od_subindex)
				`RTDOB_SUB_COUNT:
				begin
					next_rdata = {24'h0, `RTDOB_VENDOR_COUNT};
					wr_ok      = 1'b0;
					next_err   = od_we;
				end
				`RTDOB_SUB_OFS_A:
					next_rdata = {{16{sel_calib.offset_a[15]}},
						sel_calib.offset_a};
				`RTDOB_SUB_GAIN_A:
					next_rdata = {16'h0, sel_calib.gain_a};
				`RTDOB_SUB_OFS_B:
					next_rdata = {{16{sel_calib.offset_b[15]}},
						sel_calib.offset_b};
				`RTDOB_SUB_GAIN_B:
					next_rdata = {16'h0, sel_calib.gain_b};
				default:
				begin
					wr_ok    = 1'b0;
					next_err = 1'b1;
				end
			endcase
		end
		else if (od_index == `RTDOB_IDX_PROFILE)
		begin
			unique case (od_subindex)
				`RTDOB_SUB_COUNT:
					next_rdata = {24'h0, `RTDOB_PROFILE_COUNT};
				`RTDOB_SUB_SPACING:
					next_rdata = {16'h0, `RTDOB_SPACING};
				`RTDOB_SUB_CHANNELS:
					next_rdata = {28'h0, CH_LIMIT};
				default:
					next_err = 1'b1;
			endcase
			if (od_we)
				next_err = 1'b1;
		end
		else if (od_index == `RTDOB_IDX_CODE &&
			od_subindex == `RTDOB_SUB_COUNT)
		begin
			next_rdata = reserved_key_word;
			wr_ok      = od_we;
		end
		else if (od_index == `RTDOB_IDX_MODLIST)
		begin
			if (od_subindex == `RTDOB_SUB_COUNT)
				next_rdata = {28'h0, CH_LIMIT};
			else if (od_subindex <= {4'h0, CH_LIMIT})
				next_rdata = `RTDOB_PROFILE_NUM;
			else
				next_err = 1'b1;
			if (od_we)
				next_err = 1'b1;
		end
		else
		begin
			next_err = 1'b1;
		end
	end

	assign restore_hit = od_req && wr_ok
		&& od_index == `RTDOB_IDX_RESTORE
		&& od_wdata == `RTDOB_RESTORE_KEY;

	// Answer one cycle after each request
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			od_ack   <= 1'b0;
			od_err   <= 1'b0;
			od_rdata <= 32'h00000000;
		end
		else
		begin
			od_ack   <= od_req;
			od_err   <= od_req && next_err;
			od_rdata <= od_req && !od_we ? next_rdata : 32'h00000000;
		end
	end

	// Restore entry and reserved key word
	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			restore_defaults_key <= 32'h00000000;
			reserved_key_word    <= 32'h00000000;
		end
		else if (od_req && wr_ok)
		begin
			if (od_index == `RTDOB_IDX_RESTORE)
				restore_defaults_key <= od_wdata;
			else if (od_index == `RTDOB_IDX_CODE)
				reserved_key_word <= od_wdata;
		end
	end

	// Factory calibration per channel, restored by the key
	generate
		for (gi = 0; gi < CHANNELS; gi++)
		begin : g_calib
			always_ff @(posedge ref_clk)
			begin
				if (sys_rst || restore_hit)
				begin
					calib[gi] <= {FACTORY_OFFSET, FACTORY_GAIN,
						FACTORY_OFFSET, FACTORY_GAIN};
				end
				else if (od_req && wr_ok && sel_ch == 3'(gi)
					&& chan_hit(od_index, `RTDOB_IDX_VENDOR))
				begin
					unique case (od_subindex)
						`RTDOB_SUB_OFS_A:
							calib[gi].offset_a <= od_wdata[15:0];
						`RTDOB_SUB_GAIN_A:
							calib[gi].gain_a <= od_wdata[15:0];
						`RTDOB_SUB_OFS_B:
							calib[gi].offset_b <= od_wdata[15:0];
						`RTDOB_SUB_GAIN_B:
							calib[gi].gain_b <= od_wdata[15:0];
						default:
							calib[gi] <= calib[gi];
					endcase
				end
			end
		end
	endgenerate

	AST_RESTORE_KEY: assert property (
		od_req && od_we && od_index == `RTDOB_IDX_RESTORE
		&& od_subindex == `RTDOB_SUB_RAW
		&& od_wdata == `RTDOB_RESTORE_KEY
		|=> calib[0] == {FACTORY_OFFSET, FACTORY_GAIN,
			FACTORY_OFFSET, FACTORY_GAIN})
		else $error("key write did not restore calibration");

	AST_RESTORE_OTHER: assert property (
		od_req && od_we && od_index == `RTDOB_IDX_RESTORE
		&& od_wdata != `RTDOB_RESTORE_KEY
		|=> $stable(calib[0]))
		else $error("non-key write changed calibration");

	AST_CALIB_WRITE: assert property (
		od_req && od_we && od_index == `RTDOB_IDX_VENDOR
		&& od_subindex == `RTDOB_SUB_GAIN_B
		|=> calib[0].gain_b == $past(od_wdata[15:0]) && !od_err)
		else $error("calibration gain write not stored");

	AST_SPACING_READ: assert property (
		od_req && !od_we && od_index == `RTDOB_IDX_PROFILE
		&& od_subindex == `RTDOB_SUB_SPACING
		|=> od_ack && od_rdata == 32'h00000010)
		else $error("index spacing read wrong");

	AST_CHAN1_READ: assert property (
		od_req && !od_we && od_index == 16'h6010
		&& od_subindex == `RTDOB_SUB_TOGGLE && CHANNELS > 1
		|=> od_rdata == {31'h0, $past(status[CHANNELS > 1 ? 1 : 0].toggle)})
		else $error("second channel not at spacing sixteen");

	AST_RES_READ: assert property (
		od_req && !od_we && od_index == `RTDOB_IDX_INTERNAL
		&& od_subindex == `RTDOB_SUB_RES
		|=> od_rdata == {16'h0, $past(status[0].resistance)})
		else $error("resistance readout wrong");

	AST_RO_WRITE: assert property (
		od_req && od_we && od_index == `RTDOB_IDX_INPUT && !sample_valid[0]
		|=> od_err && $stable(status[0].reading))
		else $error("write to read-only reading accepted");

	AST_ACK_ONCE: assert property (
		od_req |=> od_ack)
		else $error("request not answered next cycle");

endmodule : rtdob_bank

//--- sim/rtdob_master_model.sv
// Object bus master model of the channel object bank
module rtdob_master_model
(
	input  wire logic        ref_clk,
	input  wire logic        od_ack,
	input  wire logic        od_err,
	input  wire logic [31:0] od_rdata,
	output logic             od_req,
	output logic             od_we,
	output logic [15:0]      od_index,
	output logic [7:0]       od_subindex,
	output logic [31:0]      od_wdata
);
	timeunit 1ns;
	timeprecision 100ps;

	initial
	begin
		od_req      = 1'b0;
		od_we       = 1'b0;
		od_index    = 16'h0000;
		od_subindex = 8'h00;
		od_wdata    = 32'h00000000;
	end

	// One access; the answer must come exactly one cycle after the request
	task automatic access(input logic we, input logic [15:0] index,
		input logic [7:0] sub, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic err, output logic ok);
		@(posedge ref_clk);
		#1;
		od_req      = 1'b1;
		od_we       = we;
		od_index    = index;
		od_subindex = sub;
		od_wdata    = wdata;
		@(posedge ref_clk);
		#1;
		od_req      = 1'b0;
		ok          = (od_ack === 1'b1);
		err         = od_err;
		rdata       = od_rdata;
		// Released lines show the bitwise inverse of the last value, never the last value
		od_we       = ~we;
		od_index    = ~index;
		od_subindex = ~sub;
		od_wdata    = ~wdata;
	endtask : access
endmodule : rtdob_master_model

//--- sim/testbench.sv
// Random and corner-case bench of the channel object bank
`include "rtdob_consts.svh"

module testbench;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int          CH = 8;
	localparam logic [15:0] FO = 16'h8123;
	localparam logic [15:0] FG = 16'h4000;
	localparam logic [15:0] TIX [10] = '{16'h6000, 16'h800e, 16'h800f,
		16'hf000, 16'hf000, 16'hf000, 16'hf010, 16'h1011, 16'h1011, 16'hf008};
	localparam logic [7:0]  TSB [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
		8'h02, 8'h00, 8'h00, 8'h01, 8'h00};
	localparam logic [31:0] TXD [10] = '{32'h11, 32'h04, 32'h04, 32'h02,
		32'h10, 32'(CH), 32'(CH), 32'h01, 32'h00, 32'h00};

	logic                     ref_clk = 1'b0;
	logic                     sys_rst = 1'b1;
	logic [CH-1:0]            sample_valid = '0;
	rtdob_pkg::rtdob_sample_s sample [CH];
	rtdob_pkg::rtdob_calib_s  calib [CH];
	rtdob_pkg::rtdob_status_s exp_st [CH];
	rtdob_pkg::rtdob_calib_s  exp_cal [CH];
	logic                     od_req, od_we, od_ack, od_err;
	logic [15:0]              od_index;
	logic [7:0]               od_subindex;
	logic [31:0]              od_wdata, od_rdata;
	logic [31:0]              seed = 32'h6437002d;
	int                       err_count = 0;
	int                       checks = 0;

	always #4 ref_clk = ~ref_clk;

	rtdob_bank #(.CHANNELS(CH), .FACTORY_OFFSET(FO), .FACTORY_GAIN(FG)) DUT
	(
		.ref_clk(ref_clk), .sys_rst(sys_rst), .sample_valid(sample_valid),
		.sample(sample), .calib(calib), .od_req(od_req), .od_we(od_we),
		.od_index(od_index), .od_subindex(od_subindex),
		.od_wdata(od_wdata), .od_ack(od_ack), .od_err(od_err),
		.od_rdata(od_rdata)
	);

	rtdob_master_model MODEL
	(
		.ref_clk(ref_clk), .od_ack(od_ack), .od_err(od_err),
		.od_rdata(od_rdata), .od_req(od_req), .od_we(od_we),
		.od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata)
	);

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic rtdob_pkg::rtdob_sample_s rnd_sample();
		logic [31:0] a;
		logic [31:0] b;
		a = rnd();
		b = rnd();
		return {b[3:0], a[31:16], rnd(), a[15:0]};
	endfunction : rnd_sample

	function automatic rtdob_pkg::rtdob_status_s exp_of(
		rtdob_pkg::rtdob_sample_s s, logic t);
		rtdob_pkg::rtdob_status_s r;
		r.below      = s.below;
		r.above      = s.above | s.open_circuit;
		r.error      = s.invalid | s.open_circuit;
		r.validity   = r.error;
		r.toggle     = ~t;
		r.reading    = s.reading;
		r.raw        = s.raw;
		r.resistance = s.resistance;
		return r;
	endfunction : exp_of

	function automatic logic [31:0] sext(logic [15:0] f);
		return {{16{f[15]}}, f};
	endfunction : sext

	task automatic check_word(input logic [63:0] g, input logic [63:0] e);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %0t value %h, expected %h", $time, g, e);
		end
	endtask : check_word

	task automatic check_err(input logic [1:0] g, input logic [1:0] e);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %0t ack/err %b, expected %b", $time, g, e);
		end
	endtask : check_err

	task automatic acc(input logic we, input logic [15:0] ix,
		input logic [7:0] sb, input logic [31:0] wd, input logic xe,
		input logic [31:0] xd);
		logic [31:0] d;
		logic        e;
		logic        ok;
		MODEL.access(we, ix, sb, wd, d, e, ok);
		check_err({ok, e}, {1'b1, xe});
		if (!xe)
			check_word(64'(d), 64'(xd));
	endtask : acc

	task automatic rd(input logic [15:0] ix, input logic [7:0] sb,
		input logic [31:0] xd);
		acc(1'b0, ix, sb, '0, 1'b0, xd);
	endtask : rd

	task automatic check_chan(input int c);
		logic [15:0] b;
		b = `RTDOB_IDX_INPUT + 16'(c * 16);
		rd(b, `RTDOB_SUB_BELOW, 32'(exp_st[c].below));
		rd(b, `RTDOB_SUB_ABOVE, 32'(exp_st[c].above));
		rd(b, `RTDOB_SUB_ERROR, 32'(exp_st[c].error));
		rd(b, `RTDOB_SUB_VALIDITY, 32'(exp_st[c].validity));
		rd(b, `RTDOB_SUB_TOGGLE, 32'(exp_st[c].toggle));
		rd(b, `RTDOB_SUB_READING, sext(exp_st[c].reading));
		b = `RTDOB_IDX_INTERNAL + 16'(c * 16);
		rd(b, `RTDOB_SUB_RAW, exp_st[c].raw);
		rd(b, `RTDOB_SUB_RES, 32'(exp_st[c].resistance));
	endtask : check_chan

	task automatic drive(input int c, input rtdob_pkg::rtdob_sample_s s,
		input logic last);
		@(posedge ref_clk);
		#1;
		sample[c]       = s;
		sample_valid[c] = 1'b1;
		exp_st[c]       = exp_of(s, exp_st[c].toggle);
		if (last)
		begin
			@(posedge ref_clk);
			#1;
			sample_valid[c] = 1'b0;
			sample[c]       = ~s;
		end
	endtask : drive

	task automatic report_and_stop;
		$display("Comparisons: %0d, mismatches: %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	initial
	begin
		logic [31:0]              k;
		logic [15:0]              b;
		logic [15:0]              f;
		rtdob_pkg::rtdob_sample_s s;
		int                       c;
		foreach (sample[i])
			sample[i] = '0;
		repeat (8) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		for (c = 0; c < CH; c++)
		begin
			exp_st[c] = '0;
			check_chan(c);
			check_word(calib[c], {FO, FG, FO, FG});
		end
		for (c = 0; c < 10; c++)
			rd(TIX[c], TSB[c], TXD[c]);
		for (c = 1; c <= CH; c++)
			rd(16'hf010, 8'(c), 32'h140);
		acc(1'b0, 16'hf010, 8'(CH + 1), '0, 1'b1, '0);
		acc(1'b0, 16'h6000 + 16'(CH * 16), 8'h11, '0, 1'b1, '0);
		acc(1'b0, 16'h6000, 8'h03, '0, 1'b1, '0);
		acc(1'b1, 16'h6000, 8'h11, rnd(), 1'b1, '0);
		acc(1'b1, 16'h6000, 8'h01, rnd(), 1'b1, '0);
		acc(1'b1, 16'h800e, 8'h02, rnd(), 1'b1, '0);
		acc(1'b1, 16'hf000, 8'h01, rnd(), 1'b1, '0);
		acc(1'b1, 16'h1011, 8'h00, rnd(), 1'b1, '0);
		acc(1'b1, 16'h800f, 8'h00, rnd(), 1'b1, '0);
		check_chan(0);
		for (int i = 0; i < 24; i++)
		begin
			c = rnd() % CH;
			s = rnd_sample();
			if (i % 3 == 0)
				s[67:64] = 4'b0010;
			if (i % 4 == 1)
				drive(c, rnd_sample(), 1'b0);
			drive(c, s, 1'b1);
			check_chan(c);
		end
		@(posedge ref_clk);
		#1;
		sys_rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		foreach (exp_st[i])
			exp_st[i] = '0;
		check_chan(c);
		for (c = 0; c < CH; c++)
		begin
			exp_cal[c] = {rnd(), rnd()};
			b = `RTDOB_IDX_VENDOR + 16'(c * 16);
			for (int j = 0; j < 4; j++)
				acc(1'b1, b, 8'(j + 1), 32'(exp_cal[c][63-16*j -: 16]), 1'b0, '0);
			check_word(calib[c], exp_cal[c]);
			for (int j = 0; j < 4; j++)
			begin
				f = exp_cal[c][63-16*j -: 16];
				rd(b, 8'(j + 1), (j % 2 == 0) ? sext(f) : {16'h0, f});
			end
		end
		k = rnd() | 32'h1;
		acc(1'b1, `RTDOB_IDX_RESTORE, 8'h01, k, 1'b0, '0);
		rd(`RTDOB_IDX_RESTORE, 8'h01, k);
		for (c = 0; c < CH; c++)
			check_word(calib[c], exp_cal[c]);
		acc(1'b1, `RTDOB_IDX_RESTORE, 8'h01, `RTDOB_RESTORE_KEY, 1'b0, '0);
		for (c = 0; c < CH; c++)
			check_word(calib[c], {FO, FG, FO, FG});
		rd(16'h807f, 8'h01, sext(FO));
		k = rnd();
		acc(1'b1, 16'hf008, 8'h00, k, 1'b0, '0);
		rd(16'hf008, 8'h00, k);
		report_and_stop();
	end
endmodule : testbench
